// File: core/cisr_pkg.sv
// Constants, register map and encodings for the store/return executor
package cisr_pkg;
    // Clock and instruction cycle timing
    localparam int CLK_MHZ   = 250;
    localparam int INSTR_NS  = 16;
    localparam int CYCLE_DIV = (INSTR_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] CNT_LAST = 3'(CYCLE_DIV - 1);

    // Register byte offsets
    localparam logic [5:0] OFS_CMD     = 6'h00;
    localparam logic [5:0] OFS_ACC     = 6'h04;
    localparam logic [5:0] OFS_PTR0    = 6'h08;
    localparam logic [5:0] OFS_PTR1    = 6'h0c;
    localparam logic [5:0] OFS_OPTION  = 6'h10;
    localparam logic [5:0] OFS_FLAGS   = 6'h14;
    localparam logic [5:0] OFS_INTCTL  = 6'h18;
    localparam logic [5:0] OFS_PWRCTL  = 6'h1c;
    localparam logic [5:0] OFS_PC      = 6'h20;

    // Command word field positions, plus enable and reset flag bits
    localparam int CMD_W        = 12;
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_N_BIT    = 3;
    localparam int CMD_MM_LSB   = 4;
    localparam int CMD_K_LSB    = 6;
    localparam int CMD_BUSY_BIT = 16;
    localparam int GIE_BIT      = 7;
    localparam int RI_BIT       = 2;

    // Operation codes
    localparam logic [2:0] OP_NOP       = 3'h0;
    localparam logic [2:0] OP_STORE     = 3'h1;
    localparam logic [2:0] OP_STORE_REL = 3'h2;
    localparam logic [2:0] OP_OPTION    = 3'h3;
    localparam logic [2:0] OP_RESET     = 3'h4;
    localparam logic [2:0] OP_RETFI     = 3'h5;
    localparam logic [2:0] OP_RETSUB    = 3'h6;

    // Pointer mode codes
    localparam logic [1:0] MM_PRE_INC  = 2'h0;
    localparam logic [1:0] MM_PRE_DEC  = 2'h1;
    localparam logic [1:0] MM_POST_INC = 2'h2;
    localparam logic [1:0] MM_POST_DEC = 2'h3;

    // Values after reset
    localparam logic [15:0] RST_PTR    = 16'h0000;
    localparam logic [7:0]  RST_OPTION = 8'hff;
    localparam logic [7:0]  RST_INTCTL = 8'h00;
    localparam logic        RST_RI     = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_EXEC   = 3'b010,
        ST_SECOND = 3'b100
    } cisr_state_e;
endpackage : cisr_pkg

// File: core/cisr_core.sv
// Executor for indirect store, option load, reset and return operations
// Behaviour
// - Store accumulator at selected pointer's address
// - Pre modes adjust first, post modes after
// - Mode codes: preinc, predec, postinc, postdec
// - Relative form adds signed offset, pointer kept
// - Pointers are 16 bits and wrap silently
// - Store and pointer updates leave flags alone
// - Option load copies accumulator, flags untouched
// - Soft reset resets device, clears reset flag
// - Interrupt return pops, loads PC, sets enable
// - Subroutine return pops, loads PC, two cycles
`timescale 1ns/10ps
module cisr_core
    import cisr_pkg::*;
#(
    parameter int PC_W = 15
) (
    input  wire logic            core_clk_in,
    input  wire logic            srst_in,
    input  wire logic [5:0]      avs_address_in,
    input  wire logic            avs_read_in,
    input  wire logic            avs_write_in,
    input  wire logic [31:0]     avs_writedata_in,
    input  wire logic [3:0]      avs_byteenable_in,
    output logic      [31:0]     avs_readdata_out,
    output logic                 avs_waitrequest_out,
    output logic                 mem_wr_out,
    output logic      [15:0]     mem_addr_out,
    output logic      [7:0]      mem_wdata_out,
    output logic                 stack_pop_out,
    input  wire logic [PC_W-1:0] stack_top_in,
    output logic                 soft_reset_out,
    output logic      [7:0]      option_out,
    output logic                 gie_out
);
    localparam int CYC_SPAN = CYCLE_DIV;

    cisr_state_e      state;
    logic [2:0]       cyc_cnt;
    logic             cyc_en;
    logic             soft_rst;
    logic             rst_all;
    logic             ack;
    logic             req;
    logic             cmd_stall;
    logic             accept;
    logic             wr_en;
    logic [CMD_W-1:0] cmd;
    logic [7:0]       acc;
    logic [15:0]      ptr [2];
    logic [7:0]       option;
    logic [2:0]       flags;
    logic [7:0]       intctl;
    logic             ri;
    logic [PC_W-1:0]  pc;
    logic [2:0]       op;
    logic             sel_n;
    logic [1:0]       mm;
    logic [15:0]      k_ext;
    logic [15:0]      sel_ptr;
    logic [15:0]      eff_addr;
    logic [15:0]      next_ptr;
    logic             do_exec;
    logic             is_store;
    logic             is_ret;

    // Byte lanes of a write merged over the old word
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // A soft reset clears everything the hardware reset clears except soft_rst itself and ri, which it clears where the pin sets it
    assign rst_all = srst_in | soft_rst;

    // Instruction cycle enable from the core clock
    always_ff @(posedge core_clk_in) begin
        if (rst_all || cyc_en) begin
            cyc_cnt <= 3'h0;
        end else begin
            cyc_cnt <= cyc_cnt + 3'h1;
        end
    end
    assign cyc_en = (cyc_cnt == CNT_LAST);

    // Bus handshake; a command write stalls while one is running
    assign req       = avs_read_in | avs_write_in;
    assign cmd_stall = avs_write_in && (avs_address_in == OFS_CMD)
                       && (state != ST_IDLE);
    assign accept    = req && !ack && !cmd_stall;
    assign wr_en     = accept && avs_write_in;
    assign avs_waitrequest_out = req && !ack;

    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            ack <= 1'b0;
        end else begin
            ack <= accept;
        end
    end

    // Command decode
    assign op      = cmd[CMD_OP_LSB +: 3];
    assign sel_n   = cmd[CMD_N_BIT];
    assign mm      = cmd[CMD_MM_LSB +: 2];
    assign k_ext   = {{10{cmd[CMD_K_LSB + 5]}}, cmd[CMD_K_LSB +: 6]};
    assign sel_ptr = ptr[sel_n];
    assign do_exec  = (state == ST_EXEC) && cyc_en;
    assign is_store = (op == OP_STORE) || (op == OP_STORE_REL);
    assign is_ret   = (op == OP_RETFI) || (op == OP_RETSUB);

    // Effective address and pointer after the store; sums wrap at 16 bits
    always_comb begin
        eff_addr = sel_ptr;
        next_ptr = sel_ptr;
        if (op == OP_STORE_REL) begin
            eff_addr = 16'(sel_ptr + k_ext);
        end else begin
            unique case (mm)
                MM_PRE_INC: begin
                    eff_addr = 16'(sel_ptr + 16'h0001);
                    next_ptr = eff_addr;
                end
                MM_PRE_DEC: begin
                    eff_addr = 16'(sel_ptr - 16'h0001);
                    next_ptr = eff_addr;
                end
                MM_POST_INC: begin
                    next_ptr = 16'(sel_ptr + 16'h0001);
                end
                MM_POST_DEC: begin
                    next_ptr = 16'(sel_ptr - 16'h0001);
                end
            endcase
        end
    end

    // Sequencer: returns hold a second instruction cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (wr_en && avs_address_in == OFS_CMD) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (cyc_en) begin
                        state <= is_ret ? ST_SECOND : ST_IDLE;
                    end
                end
                ST_SECOND: begin
                    if (cyc_en) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Command register, only loaded while idle
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            cmd <= '0;
        end else if (wr_en && avs_address_in == OFS_CMD) begin
            cmd <= CMD_W'(be_merge(32'(cmd), avs_writedata_in,
                                   avs_byteenable_in));
        end
    end

    // Accumulator and flags belong to software; no operation here writes
    // them, so flags keep their value through every store
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            acc   <= 8'h00;
            flags <= 3'h0;
        end else if (wr_en) begin
            if (avs_address_in == OFS_ACC && avs_byteenable_in[0]) begin
                acc <= avs_writedata_in[7:0];
            end
            if (avs_address_in == OFS_FLAGS && avs_byteenable_in[0]) begin
                flags <= avs_writedata_in[2:0];
            end
        end
    end

    // Pointers; the executor wins over a bus write in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            ptr[0] <= RST_PTR;
            ptr[1] <= RST_PTR;
        end else begin
            if (wr_en && avs_address_in == OFS_PTR0) begin
                ptr[0] <= 16'(be_merge(32'(ptr[0]), avs_writedata_in,
                                       avs_byteenable_in));
            end
            if (wr_en && avs_address_in == OFS_PTR1) begin
                ptr[1] <= 16'(be_merge(32'(ptr[1]), avs_writedata_in,
                                       avs_byteenable_in));
            end
            if (do_exec && op == OP_STORE) begin
                ptr[sel_n] <= next_ptr;
            end
        end
    end

    // Data memory write port, one pulse per store
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            mem_wr_out    <= 1'b0;
            mem_addr_out  <= 16'h0000;
            mem_wdata_out <= 8'h00;
        end else begin
            mem_wr_out <= do_exec && is_store;
            if (do_exec && is_store) begin
                mem_addr_out  <= eff_addr;
                mem_wdata_out <= acc;
            end
        end
    end

    // Option register load from the accumulator
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            option <= RST_OPTION;
        end else if (do_exec && op == OP_OPTION) begin
            option <= acc;
        end else if (wr_en && avs_address_in == OFS_OPTION
                     && avs_byteenable_in[0]) begin
            option <= avs_writedata_in[7:0];
        end
    end
    assign option_out = option;

    // Interrupt control; the hardware set beats a software clear
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            intctl <= RST_INTCTL;
        end else begin
            if (wr_en && avs_address_in == OFS_INTCTL
                && avs_byteenable_in[0]) begin
                intctl <= avs_writedata_in[7:0];
            end
            if (do_exec && op == OP_RETFI) begin
                intctl[GIE_BIT] <= 1'b1;
            end
        end
    end
    assign gie_out = intctl[GIE_BIT];

    // Stack pop pulse and program counter
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            stack_pop_out <= 1'b0;
            pc            <= '0;
        end else begin
            stack_pop_out <= do_exec && is_ret;
            if (do_exec) begin
                pc <= is_ret ? stack_top_in : PC_W'(pc + 1'b1);
            end else if (wr_en && avs_address_in == OFS_PC) begin
                pc <= PC_W'(be_merge(32'(pc), avs_writedata_in,
                                     avs_byteenable_in));
            end
        end
    end

    // Soft reset pulse; it must not clear itself, so only the pin resets it
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= do_exec && (op == OP_RESET);
        end
    end
    assign soft_reset_out = soft_rst;

    // Reset cause flag: set by pin reset, cleared by soft reset
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            ri <= RST_RI;
        end else if (soft_rst) begin
            ri <= 1'b0;
        end else if (wr_en && avs_address_in == OFS_PWRCTL
                     && avs_byteenable_in[0]) begin
            ri <= avs_writedata_in[RI_BIT];
        end
    end

    // Read data captured when the read is taken
    always_ff @(posedge core_clk_in) begin
        if (rst_all) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (accept && avs_read_in) begin
            avs_readdata_out <= 32'h0000_0000;
            unique case (avs_address_in)
                OFS_CMD: begin
                    avs_readdata_out[CMD_W-1:0]   <= cmd;
                    avs_readdata_out[CMD_BUSY_BIT] <= (state != ST_IDLE);
                end
                OFS_ACC:    avs_readdata_out[7:0]      <= acc;
                OFS_PTR0:   avs_readdata_out[15:0]     <= ptr[0];
                OFS_PTR1:   avs_readdata_out[15:0]     <= ptr[1];
                OFS_OPTION: avs_readdata_out[7:0]      <= option;
                OFS_FLAGS:  avs_readdata_out[2:0]      <= flags;
                OFS_INTCTL: avs_readdata_out[7:0]      <= intctl;
                OFS_PWRCTL: avs_readdata_out[RI_BIT]   <= ri;
                OFS_PC:     avs_readdata_out[PC_W-1:0] <= pc;
                default:    avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // Checks on the executor
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_all);

    store_port_a: assert property (
        do_exec && is_store |=> mem_wr_out
            && mem_addr_out == $past(eff_addr)
            && mem_wdata_out == $past(acc))
        else $error("store did not write accumulator at address");

    pre_inc_a: assert property (
        do_exec && op == OP_STORE && mm == MM_PRE_INC
        |=> mem_addr_out == 16'($past(sel_ptr) + 16'h0001)
            && ptr[$past(sel_n)] == mem_addr_out)
        else $error("pre-increment store used wrong address");

    post_dec_a: assert property (
        do_exec && op == OP_STORE && mm == MM_POST_DEC
        |=> mem_addr_out == $past(sel_ptr)
            && ptr[$past(sel_n)] == 16'($past(sel_ptr) - 16'h0001))
        else $error("post-decrement store wrong");

    rel_keep_a: assert property (
        do_exec && op == OP_STORE_REL
        |=> ptr[$past(sel_n)] == $past(sel_ptr)
            && mem_addr_out == 16'($past(sel_ptr) + $past(k_ext)))
        else $error("relative store moved pointer or bad address");

    wrap_top_a: assert property (
        do_exec && op == OP_STORE && mm == MM_POST_INC
            && sel_ptr == 16'hffff |=> ptr[$past(sel_n)] == 16'h0000)
        else $error("pointer did not wrap to zero");

    flags_keep_a: assert property (
        state != ST_IDLE && !(wr_en && avs_address_in == OFS_FLAGS)
        |=> $stable(flags))
        else $error("flags changed by executor");

    option_load_a: assert property (
        do_exec && op == OP_OPTION |=> option_out == $past(acc)
            && $stable(flags))
        else $error("option load wrong");

    soft_reset_a: assert property (
        do_exec && op == OP_RESET |=> soft_reset_out)
        else $error("soft reset not raised");

    ri_clear_a: assert property (
        @(posedge core_clk_in) disable iff (srst_in)
        soft_rst |=> !ri && state == ST_IDLE && pc == '0)
        else $error("soft reset left state or flag");

    irq_return_a: assert property (
        do_exec && op == OP_RETFI |=> stack_pop_out && gie_out
            && pc == $past(stack_top_in) && state == ST_SECOND
            ##[1:CYC_SPAN] state == ST_IDLE)
        else $error("interrupt return wrong");

    sub_return_a: assert property (
        do_exec && op == OP_RETSUB |=> stack_pop_out
            && pc == $past(stack_top_in)
            ##1 (state == ST_SECOND)[*3] ##1 state == ST_IDLE)
        else $error("subroutine return not two cycles");

    nop_step_a: assert property (
        do_exec && op == OP_NOP |=> pc == PC_W'($past(pc) + 1'b1)
            && !mem_wr_out && !stack_pop_out && state == ST_IDLE)
        else $error("no-op did more than advance");

    cov_store_c:  cover property (do_exec && op == OP_STORE);
    cov_rel_c:    cover property (do_exec && op == OP_STORE_REL);
    cov_retfi_c:  cover property (do_exec && op == OP_RETFI);
    cov_reset_c:  cover property (do_exec && op == OP_RESET);
endmodule : cisr_core

// File: verification/cisr_mem_stack_model.sv
// Data memory and hardware return stack facing the executor
`timescale 1ns/10ps
module cisr_mem_stack_model #(
    parameter logic [14:0] RET_A = 15'h1234,
    parameter logic [14:0] RET_B = 15'h0abc
) (
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire logic        mem_wr_in,
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [7:0]  mem_wdata_in,
    input  wire logic        stack_pop_in,
    output logic      [14:0] stack_top_out
);
    logic [7:0] mem [0:65535];
    logic [1:0] sp;

    // Byte lands on the strobe edge; nothing is read back by this block
    always_ff @(posedge core_clk_in) begin
        if (mem_wr_in) begin
            mem[mem_addr_in] <= mem_wdata_in;
        end
    end

    // Each pop exposes the next entry
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            sp <= 2'h0;
        end else if (stack_pop_in) begin
            sp <= sp + 2'h1;
        end
    end

    // Popping past the loaded entries gives sp XORed into a fixed pattern for two pops; the fourth pop wraps sp to zero and RET_A repeats
    always_comb begin
        case (sp)
            2'h0:    stack_top_out = RET_A;
            2'h1:    stack_top_out = RET_B;
            default: stack_top_out = {13'h0aaa, sp} ^ 15'h5555;
        endcase
    end
endmodule : cisr_mem_stack_model

// File: verification/cisr_core_tb.sv
// Self-checking bench for the store and return executor
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    n_fail++; $display("CHECK FAILED %s expected %h seen %h", \
    what, exp, got); end end
module cisr_core_tb
    import cisr_pkg::*;
;
    localparam logic [14:0] RET_A = 15'h1234;
    localparam logic [14:0] RET_B = 15'h0abc;
    logic        clk   = 1'b0;
    logic        srst  = 1'b1;
    logic [5:0]  addr  = 6'h00;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be    = 4'hf;
    logic [31:0] rdata, v;
    logic        waitreq, mem_wr, pop, soft_rst, global_irq_enable;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata, option, b;
    logic [14:0] stack_top;
    int          n_fail = 0, n_tests = 0, n_wr = 0, n_pop = 0, n_srst = 0;

    cisr_core u_cisr_core (
        .core_clk_in(clk), .srst_in(srst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .mem_wr_out(mem_wr),
        .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
        .stack_pop_out(pop), .stack_top_in(stack_top),
        .soft_reset_out(soft_rst), .option_out(option), .gie_out(global_irq_enable));

    cisr_mem_stack_model #(.RET_A(RET_A), .RET_B(RET_B))
        u_cisr_mem_stack_model (
        .core_clk_in(clk), .srst_in(srst), .mem_wr_in(mem_wr),
        .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
        .stack_pop_in(pop), .stack_top_out(stack_top));

    always #2 clk = ~clk;

    // Strobe counters let a scenario prove one op gave exactly one pulse
    always @(posedge clk) begin
        if (mem_wr === 1'b1) n_wr <= n_wr + 1;
        if (pop === 1'b1) n_pop <= n_pop + 1;
        if (soft_rst === 1'b1) n_srst <= n_srst + 1;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // Held until a rising edge sees waitrequest low; read data taken there
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        logic ws;
        ws = 1'b1;
        @(posedge clk);
        wr    <= w;
        rd    <= !w;
        addr  <= a;
        wdata <= d;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            ws = waitreq;
            q  = rdata;
            if (ws === 1'b0) break;
        end
        `CHK("waitrequest", 1'b0, ws)
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg

    task automatic rreg(input logic [5:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rreg

    function automatic logic [31:0] cmd(logic [2:0] op, logic n,
                                        logic [1:0] mm, logic [5:0] k);
        return {20'h0, k, mm, n, op};
    endfunction : cmd

    // Issue a command and poll busy until the op has retired
    task automatic exec(input logic [31:0] c);
        wreg(OFS_CMD, c);
        for (int k = 0; k < 20; k++) begin
            rreg(OFS_CMD, v);
            if (v[CMD_BUSY_BIT] === 1'b0) break;
        end
        `CHK("busy", 1'b0, v[CMD_BUSY_BIT])
    endtask : exec

    task automatic t_reset_values;
        rreg(OFS_PWRCTL, v);
        `CHK("reset flag", 1'b1, v[RI_BIT])
        `CHK("option pin", 8'hff, option)
        wreg(6'h3c, 32'h5a);
        rreg(6'h3c, v);
        `CHK("unmapped", 32'h0, v)
    endtask : t_reset_values

    // All four modes, each at a pointer wrap boundary
    task automatic t_store_modes;
        logic [15:0] p, fin, ea;
        logic [7:0]  acc;
        logic [5:0]  po;
        int          w0;
        for (int m = 0; m < 4; m++) begin
            p   = m[0] ? 16'h0000 : 16'hffff;
            fin = m[0] ? p - 16'h1 : p + 16'h1;
            ea  = m[1] ? p : fin;
            acc = {6'h28, m[1:0]};
            po  = m[0] ? OFS_PTR1 : OFS_PTR0;
            wreg(po, {16'h0, p});
            wreg(OFS_ACC, {24'h0, acc});
            w0 = n_wr;
            exec(cmd(OP_STORE, m[0], m[1:0], 6'h00));
            b = u_cisr_mem_stack_model.mem[ea];
            `CHK("store strobes", w0 + 1, n_wr)
            `CHK("store address", ea, mem_addr)
            `CHK("stored byte", acc, b)
            rreg(po, v);
            `CHK("pointer after", {16'h0, fin}, v)
            rreg(OFS_FLAGS, v);
            `CHK("flags kept", 32'h5, v)
        end
    endtask : t_store_modes

    // Offset at both ends of its signed range
    task automatic t_store_rel;
        logic [5:0]  ks [2] = '{6'h20, 6'h1f};
        logic [15:0] ea [2] = '{16'h0fe0, 16'h101f};
        logic [5:0]  po;
        for (int i = 0; i < 2; i++) begin
            po = i[0] ? OFS_PTR1 : OFS_PTR0;
            wreg(po, 32'h1000);
            wreg(OFS_ACC, 32'h5c + i);
            exec(cmd(OP_STORE_REL, i[0], 2'h0, ks[i]));
            b = u_cisr_mem_stack_model.mem[ea[i]];
            `CHK("offset address", ea[i], mem_addr)
            `CHK("offset byte", 8'h5c + 8'(i), b)
            rreg(po, v);
            `CHK("pointer kept", 32'h1000, v)
            rreg(OFS_FLAGS, v);
            `CHK("flags kept", 32'h5, v)
        end
    endtask : t_store_rel

    task automatic t_option_nop;
        logic [31:0] pc0;
        int          w0;
        wreg(OFS_ACC, 32'h3c);
        exec(cmd(OP_OPTION, 1'b0, 2'h0, 6'h00));
        `CHK("option pin", 8'h3c, option)
        rreg(OFS_FLAGS, v);
        `CHK("flags kept", 32'h5, v)
        rreg(OFS_PC, pc0);
        w0 = n_wr;
        exec(cmd(OP_NOP, 1'b0, 2'h0, 6'h00));
        rreg(OFS_PC, v);
        `CHK("pc advance", (pc0 + 32'h1) & 32'h7fff, v)
        `CHK("no write", w0, n_wr)
        rreg(OFS_PTR0, v);
        `CHK("pointer kept", 32'h1000, v)
        `CHK("option kept", 8'h3c, option)
    endtask : t_option_nop

    task automatic t_returns;
        int p0;
        p0 = n_pop;
        wreg(OFS_INTCTL, 32'h0);
        exec(cmd(OP_RETFI, 1'b0, 2'h0, 6'h00));
        `CHK("one pop", p0 + 1, n_pop)
        `CHK("enable pin", 1'b1, global_irq_enable)
        rreg(OFS_PC, v);
        `CHK("pc popped", {17'h0, RET_A}, v)
        rreg(OFS_INTCTL, v);
        `CHK("enable bit", 1'b1, v[GIE_BIT])
        wreg(OFS_INTCTL, 32'h0);
        exec(cmd(OP_RETSUB, 1'b0, 2'h0, 6'h00));
        `CHK("one pop", p0 + 2, n_pop)
        `CHK("enable kept", 1'b0, global_irq_enable)
        rreg(OFS_PC, v);
        `CHK("pc popped", {17'h0, RET_B}, v)
        rreg(OFS_FLAGS, v);
        `CHK("flags kept", 32'h5, v)
    endtask : t_returns

    task automatic t_soft_reset;
        int s0;
        wreg(OFS_PTR1, 32'h4321);
        wreg(OFS_INTCTL, 32'h80);
        s0 = n_srst;
        exec(cmd(OP_RESET, 1'b0, 2'h0, 6'h00));
        `CHK("reset pulse", s0 + 1, n_srst)
        `CHK("option reset", 8'hff, option)
        `CHK("enable reset", 1'b0, global_irq_enable)
        rreg(OFS_PTR1, v);
        `CHK("pointer reset", 32'h0, v)
        rreg(OFS_PC, v);
        `CHK("pc reset", 32'h0, v)
        rreg(OFS_PWRCTL, v);
        `CHK("reset flag", 1'b0, v[RI_BIT])
    endtask : t_soft_reset

    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset_values();
        wreg(OFS_FLAGS, 32'h5);
        t_store_modes();
        t_store_rel();
        t_option_nop();
        t_returns();
        t_soft_reset();
        end_of_test();
    end

    // Whole run needs a few hundred cycles; this cuts off a hang
    initial begin
        #(4 * 20000);
        n_fail++;
        end_of_test();
    end
endmodule : cisr_core_tb
